// ===== inc/echo_cfg_pkg.sv
//----------------------------------------------------------------------
// Purpose: constants and carrier types for the echo filter config block
// Assumes: 20 MHz system clock
// Notes: register offsets are byte addresses on the micro port
//----------------------------------------------------------------------
package echo_cfg_pkg;
   // register map
   localparam logic [7:0] SAWTOOTH_OFFSET_CFG_ADDR = 8'h70;
   localparam logic [7:0] SPRING_TIMER_CFG_ADDR = 8'h71;
   localparam logic [7:0] ECHO_PATH_DELAY_ADDR = 8'h72;
   localparam logic [7:0] VOICE_DETECT_INTERVALS_ADDR = 8'h73;
   localparam logic [7:0] VOICE_DETECT_HYST_GAP_ADDR = 8'h74;
   localparam logic [7:0] VOICE_DETECT_COUNT_INIT_ADDR = 8'h75;
   // reset values
   localparam logic [7:0] SAWTOOTH_OFFSET_CFG_RST = 8'h00;
   localparam logic [7:0] SPRING_TIMER_CFG_RST = 8'h44;
   localparam logic [3:0] ECHO_PATH_DELAY_RST = 4'hF;
   localparam logic [7:0] VOICE_DETECT_INTERVALS_RST = 8'h77;
   localparam logic [7:0] VOICE_DETECT_HYST_GAP_RST = 8'h74;
   localparam logic [7:0] VOICE_DETECT_COUNT_INIT_RST = 8'h85;
   // field positions
   localparam int RISE_LSB = 0;
   localparam int OFFSET_LSB = 3;
   localparam int QUIET_CHECK_LSB = 0;
   localparam int MAX_SEARCH_LSB = 4;
   localparam int MARGIN_LSB = 0;
   localparam int HANGOVER_LSB = 4;
   localparam logic [7:0] SPRING_FIELD_MASK = 8'h77;
   // delay codes and channel grouping
   localparam logic [3:0] DELAY_CODE_64MS = 4'h7;
   localparam int CHAN_GROUP_BIT = 2;
   // no-voice counter
   localparam int CNT_W = 11;
   localparam logic [10:0] QUIET_THR_64 = 11'h200;
   localparam logic [10:0] QUIET_THR_128 = 11'h400;
   localparam int INIT_SHIFT_64 = 1;
   localparam int INIT_SHIFT_128 = 2;
   // timing: one interval step
   localparam int CLK_PERIOD_NS = 50;
   localparam int STEP_MS = 8;
   localparam int STEP_CYCLES = STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SAW_PRESCALE_W = 8;

   typedef struct packed {
      logic [4:0] chan;
      logic [7:0] amp;
      logic [3:0] level;
   } rx_sample_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;
endpackage : echo_cfg_pkg

// ===== hdl/echo_filter_voice_detect_cfg.sv
//----------------------------------------------------------------------
// Purpose: echo filter delay, tandem split, no-voice detector, damping
//          and saw-tooth configuration logic
// Assumes: register port and sample inputs synchronous to clk_sys_in
// Notes: per-channel detector state held in small arrays
//----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module echo_filter_voice_detect_cfg
   import echo_cfg_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES,
   parameter int CHANNELS = 32
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // microprocessor register port
   input wire reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   // mode pins and configuration levels
   input wire logic delay_range_sel_0_in,
   input wire logic delay_range_sel_1_in,
   input wire logic quiet_hysteresis_enable_in,
   input wire logic [3:0] quiet_amplitude_floor_in,
   input wire logic coeff_freeze_in,
   // received samples
   input wire logic sample_valid_in,
   input wire rx_sample_t sample_in,
   // results
   output logic [3:0] effective_delay_out,
   output logic chan_processed_out,
   output logic quiet_valid_out,
   output logic [4:0] quiet_chan_out,
   output logic quiet_flag_out,
   output logic damping_active_out,
   output logic [7:0] rx_dither_out
);
   //------------------------------------------------------------------
   // registers
   //------------------------------------------------------------------
   logic [7:0] saw_cfg_reg, saw_cfg_next;
   logic [7:0] spring_reg, spring_next;
   logic [3:0] delay_reg, delay_next;
   logic [7:0] intv_reg, intv_next;
   logic [7:0] hyst_gap_reg, hyst_gap_next;
   logic [7:0] cnt_init_reg, cnt_init_next;
   logic [7:0] rdata_reg, rdata_next;

   always_comb begin
      saw_cfg_next = saw_cfg_reg;
      spring_next = spring_reg;
      delay_next = delay_reg;
      intv_next = intv_reg;
      hyst_gap_next = hyst_gap_reg;
      cnt_init_next = cnt_init_reg;
      rdata_next = rdata_reg;
      if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            SAWTOOTH_OFFSET_CFG_ADDR: saw_cfg_next = reg_req_in.wdata;
            SPRING_TIMER_CFG_ADDR: spring_next = reg_req_in.wdata & SPRING_FIELD_MASK;
            ECHO_PATH_DELAY_ADDR: delay_next = reg_req_in.wdata[3:0];
            VOICE_DETECT_INTERVALS_ADDR: intv_next = reg_req_in.wdata;
            VOICE_DETECT_HYST_GAP_ADDR: hyst_gap_next = reg_req_in.wdata;
            VOICE_DETECT_COUNT_INIT_ADDR: cnt_init_next = reg_req_in.wdata;
            default: ;
         endcase
      end
      if (reg_req_in.rd) begin
         case (reg_req_in.addr)
            SAWTOOTH_OFFSET_CFG_ADDR: rdata_next = saw_cfg_reg;
            SPRING_TIMER_CFG_ADDR: rdata_next = spring_reg;
            ECHO_PATH_DELAY_ADDR: rdata_next = {4'h0, delay_reg};
            VOICE_DETECT_INTERVALS_ADDR: rdata_next = intv_reg;
            VOICE_DETECT_HYST_GAP_ADDR: rdata_next = hyst_gap_reg;
            VOICE_DETECT_COUNT_INIT_ADDR: rdata_next = cnt_init_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         saw_cfg_reg <= SAWTOOTH_OFFSET_CFG_RST;
         spring_reg <= SPRING_TIMER_CFG_RST;
         delay_reg <= ECHO_PATH_DELAY_RST;
         intv_reg <= VOICE_DETECT_INTERVALS_RST;
         hyst_gap_reg <= VOICE_DETECT_HYST_GAP_RST;
         cnt_init_reg <= VOICE_DETECT_COUNT_INIT_RST;
         rdata_reg <= 8'h00;
      end else begin
         saw_cfg_reg <= saw_cfg_next;
         spring_reg <= spring_next;
         delay_reg <= delay_next;
         intv_reg <= intv_next;
         hyst_gap_reg <= hyst_gap_next;
         cnt_init_reg <= cnt_init_next;
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata_out = rdata_reg;

   //------------------------------------------------------------------
   // mode decode
   //------------------------------------------------------------------
   logic long_mode, slave_mode, processed;
   logic [3:0] quiet_check_interval, max_search_interval;
   logic [3:0] quiet_amplitude_margin, quiet_hangover_time;
   logic [CNT_W-1:0] quiet_counter_init, quiet_thr;
   assign long_mode = delay_range_sel_1_in;
   assign slave_mode = delay_range_sel_0_in;
   assign processed = !long_mode || (sample_in.chan[CHAN_GROUP_BIT] == slave_mode);
   assign quiet_check_interval = intv_reg[QUIET_CHECK_LSB +: 4];
   assign max_search_interval = intv_reg[MAX_SEARCH_LSB +: 4];
   assign quiet_amplitude_margin = hyst_gap_reg[MARGIN_LSB +: 4];
   assign quiet_hangover_time = hyst_gap_reg[HANGOVER_LSB +: 4];
   assign quiet_counter_init = long_mode ? (CNT_W'(cnt_init_reg) << INIT_SHIFT_128)
                                         : (CNT_W'(cnt_init_reg) << INIT_SHIFT_64);
   assign quiet_thr = long_mode ? QUIET_THR_128 : QUIET_THR_64;

   //------------------------------------------------------------------
   // interval timers in 8 ms steps
   //------------------------------------------------------------------
   logic [31:0] step_cnt_reg, step_cnt_next;
   logic [3:0] chk_cnt_reg, chk_cnt_next, max_cnt_reg, max_cnt_next;
   logic chk_epoch_reg, chk_epoch_next, max_epoch_reg, max_epoch_next;
   logic [7:0] tick_reg, tick_next;
   logic step;

   always_comb begin
      step = (step_cnt_reg == 32'(STEP_CYC - 1));
      step_cnt_next = step ? 32'h0 : step_cnt_reg + 32'h1;
      chk_cnt_next = chk_cnt_reg;
      max_cnt_next = max_cnt_reg;
      chk_epoch_next = chk_epoch_reg;
      max_epoch_next = max_epoch_reg;
      tick_next = tick_reg;
      if (step) begin
         tick_next = tick_reg + 8'h1;
         if (chk_cnt_reg >= quiet_check_interval) begin
            chk_cnt_next = 4'h0;
            chk_epoch_next = !chk_epoch_reg;
         end else begin
            chk_cnt_next = chk_cnt_reg + 4'h1;
         end
         if (max_cnt_reg >= max_search_interval) begin
            max_cnt_next = 4'h0;
            max_epoch_next = !max_epoch_reg;
         end else begin
            max_cnt_next = max_cnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         step_cnt_reg <= 32'h0;
         chk_cnt_reg <= 4'h0;
         max_cnt_reg <= 4'h0;
         chk_epoch_reg <= 1'b0;
         max_epoch_reg <= 1'b0;
         tick_reg <= 8'h00;
      end else begin
         step_cnt_reg <= step_cnt_next;
         chk_cnt_reg <= chk_cnt_next;
         max_cnt_reg <= max_cnt_next;
         chk_epoch_reg <= chk_epoch_next;
         max_epoch_reg <= max_epoch_next;
         tick_reg <= tick_next;
      end
   end

   //------------------------------------------------------------------
   // per-channel no-voice detector
   //------------------------------------------------------------------
   logic [CNT_W-1:0] cnt_mem [CHANNELS];
   logic [7:0] max_cur_mem [CHANNELS];
   logic [7:0] max_ref_mem [CHANNELS];
   logic [7:0] last_mem [CHANNELS];
   logic chk_ep_mem [CHANNELS];
   logic max_ep_mem [CHANNELS];
   logic det_mem [CHANNELS];
   logic seen_mem [CHANNELS];

   logic upd, new_chk, new_max, qualify, det_now, hold, flag;
   logic [7:0] ref_v, cur_v, diff;
   logic [CNT_W-1:0] cnt_v;
   logic [7:0] age;

   always_comb begin
      upd = sample_valid_in && processed;
      new_chk = chk_ep_mem[sample_in.chan] != chk_epoch_reg;
      new_max = max_ep_mem[sample_in.chan] != max_epoch_reg;
      ref_v = new_max ? max_cur_mem[sample_in.chan] : max_ref_mem[sample_in.chan];
      if (new_max || sample_in.amp > max_cur_mem[sample_in.chan]) begin
         cur_v = sample_in.amp;
      end else begin
         cur_v = max_cur_mem[sample_in.chan];
      end
      diff = (ref_v >= sample_in.amp) ? ref_v - sample_in.amp : sample_in.amp - ref_v;
      qualify = (diff < {4'h0, quiet_amplitude_margin})
         && !((quiet_amplitude_floor_in != 4'h0)
              && (sample_in.level < quiet_amplitude_floor_in));
      if (new_chk) begin
         det_now = cnt_mem[sample_in.chan] >= quiet_thr;
         cnt_v = quiet_counter_init + CNT_W'(qualify);
      end else begin
         det_now = det_mem[sample_in.chan];
         cnt_v = cnt_mem[sample_in.chan] + CNT_W'(qualify);
      end
      age = tick_reg - last_mem[sample_in.chan];
      hold = quiet_hysteresis_enable_in && seen_mem[sample_in.chan]
         && (age <= {4'h0, quiet_hangover_time});
      flag = det_now || hold;
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < CHANNELS; i++) begin
            cnt_mem[i] <= '0;
            max_cur_mem[i] <= 8'h00;
            max_ref_mem[i] <= 8'h00;
            last_mem[i] <= 8'h00;
            chk_ep_mem[i] <= 1'b0;
            max_ep_mem[i] <= 1'b0;
            det_mem[i] <= 1'b0;
            seen_mem[i] <= 1'b0;
         end
      end else if (upd) begin
         cnt_mem[sample_in.chan] <= cnt_v;
         max_cur_mem[sample_in.chan] <= cur_v;
         max_ref_mem[sample_in.chan] <= ref_v;
         chk_ep_mem[sample_in.chan] <= chk_epoch_reg;
         max_ep_mem[sample_in.chan] <= max_epoch_reg;
         det_mem[sample_in.chan] <= det_now;
         if (det_now) begin
            last_mem[sample_in.chan] <= tick_reg;
            seen_mem[sample_in.chan] <= 1'b1;
         end
      end
   end

   //------------------------------------------------------------------
   // saw-tooth generator and registered outputs
   //------------------------------------------------------------------
   logic [SAW_PRESCALE_W-1:0] pre_reg, pre_next;
   logic [7:0] ramp_reg, ramp_next;
   logic [2:0] sawtooth_rise_rate;
   assign sawtooth_rise_rate = saw_cfg_reg[RISE_LSB +: 3];

   logic [3:0] eff_delay_next;
   logic [7:0] dither_next;
   logic damp_next;
   logic [4:0] qchan_next;
   logic qflag_next;

   always_comb begin
      pre_next = pre_reg + SAW_PRESCALE_W'(1);
      ramp_next = ramp_reg;
      // faster rise for larger codes; zero disables the ramp
      if (sawtooth_rise_rate != 3'h0 && pre_reg[3'h7 - sawtooth_rise_rate] && pre_next == '0) begin
         ramp_next = ramp_reg + 8'h1;
      end else if (sawtooth_rise_rate != 3'h0 && pre_next[3'h7 - sawtooth_rise_rate]
                   && !pre_reg[3'h7 - sawtooth_rise_rate]) begin
         ramp_next = ramp_reg + 8'h1;
      end
      dither_next = (saw_cfg_reg == 8'h00) ? 8'h00
         : ramp_reg + {3'h0, saw_cfg_reg[OFFSET_LSB +: 5]};
      eff_delay_next = (!long_mode && delay_reg > DELAY_CODE_64MS) ? DELAY_CODE_64MS
                                                                   : delay_reg;
      damp_next = (spring_reg != 8'h00) && !coeff_freeze_in;
      qchan_next = upd ? sample_in.chan : quiet_chan_out;
      qflag_next = upd ? flag : quiet_flag_out;
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pre_reg <= '0;
         ramp_reg <= 8'h00;
         rx_dither_out <= 8'h00;
         effective_delay_out <= ECHO_PATH_DELAY_RST;
         chan_processed_out <= 1'b0;
         quiet_valid_out <= 1'b0;
         quiet_chan_out <= 5'h00;
         quiet_flag_out <= 1'b0;
         damping_active_out <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         ramp_reg <= ramp_next;
         rx_dither_out <= dither_next;
         effective_delay_out <= eff_delay_next;
         chan_processed_out <= processed;
         quiet_valid_out <= upd;
         quiet_chan_out <= qchan_next;
         quiet_flag_out <= qflag_next;
         damping_active_out <= damp_next;
      end
   end
endmodule : echo_filter_voice_detect_cfg
`default_nettype wire

// ===== dv/echo_cfg_checker.sv
// Purpose: port assertions for echo_filter_voice_detect_cfg
// Assumes: one clock, async active-low reset
// Notes: bound to the block at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module echo_cfg_checker
   import echo_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // inputs watched
   input wire reg_req_t reg_req_in,
   input wire logic delay_range_sel_0_in,
   input wire logic delay_range_sel_1_in,
   input wire logic coeff_freeze_in,
   input wire logic sample_valid_in,
   input wire rx_sample_t sample_in,
   // outputs watched
   input wire logic [7:0] reg_rdata_out,
   input wire logic [3:0] effective_delay_out,
   input wire logic chan_processed_out,
   input wire logic quiet_valid_out,
   input wire logic [4:0] quiet_chan_out,
   input wire logic damping_active_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);
   logic own;
   assign own = !delay_range_sel_1_in || (delay_range_sel_0_in == sample_in.chan[CHAN_GROUP_BIT]);
   sequence s_rd(a);
      reg_req_in.rd && reg_req_in.addr == a;
   endsequence
   sequence s_take;
      sample_valid_in && own;
   endsequence
   a_delay_clamp: assert property ($past(reset_n_in) && !$past(delay_range_sel_1_in)
      |-> effective_delay_out <= DELAY_CODE_64MS) else $error("delay not clamped");
   a_chan_split: assert property ($past(reset_n_in) |-> chan_processed_out == $past(own))
      else $error("wrong channel split");
   a_take_sample: assert property (s_take |=> quiet_valid_out && quiet_chan_out == $past(sample_in.chan))
      else $error("sample not answered");
   a_refuse_chan: assert property (sample_valid_in && !own |=> !quiet_valid_out)
      else $error("foreign channel answered");
   a_valid_cause: assert property (quiet_valid_out |-> $past(sample_valid_in))
      else $error("result without sample");
   a_damp_freeze: assert property (coeff_freeze_in |=> !damping_active_out)
      else $error("damping while frozen");
   a_delay_upper: assert property (s_rd(ECHO_PATH_DELAY_ADDR) |=> reg_rdata_out[7:4] == 4'h0)
      else $error("delay upper bits set");
   a_spring_mask: assert property (s_rd(SPRING_TIMER_CFG_ADDR) |=> (reg_rdata_out & 8'h88) == 8'h00)
      else $error("spring reserved bits set");
   a_unmapped_rd: assert property (reg_req_in.rd && reg_req_in.addr > 8'h75 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule : echo_cfg_checker
bind echo_filter_voice_detect_cfg echo_cfg_checker i_chk (.clk_sys_in, .reset_n_in, .reg_req_in,
   .delay_range_sel_0_in, .delay_range_sel_1_in, .coeff_freeze_in, .sample_valid_in, .sample_in,
   .reg_rdata_out, .effective_delay_out, .chan_processed_out, .quiet_valid_out, .quiet_chan_out,
   .damping_active_out);
`default_nettype wire

// ===== dv/echo_filter_voice_detect_cfg_test.sv
// Purpose: self-checking bench for echo_filter_voice_detect_cfg
// Assumes: inputs change on the falling edge, one step is 20 cycles
// Notes: detector cases send one sample every second cycle
`timescale 1ns/10ps
`default_nettype none
module echo_filter_voice_detect_cfg_test
   import echo_cfg_pkg::*;
;
   typedef struct packed {
      logic lg; logic hy; logic [3:0] fl; logic [7:0] ci; logic [7:0] hg; logic [7:0] iv; logic ex;
   } quiet_case_t;
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   reg_req_t reg_req_in = '0;
   logic delay_range_sel_0_in = 1'b0;
   logic delay_range_sel_1_in = 1'b0;
   logic quiet_hysteresis_enable_in = 1'b0;
   logic [3:0] quiet_amplitude_floor_in = 4'h0;
   logic coeff_freeze_in = 1'b0;
   logic sample_valid_in = 1'b0;
   rx_sample_t sample_in = '0;
   logic [7:0] reg_rdata_out, rx_dither_out;
   logic [3:0] effective_delay_out;
   logic [4:0] quiet_chan_out;
   logic chan_processed_out, quiet_valid_out, quiet_flag_out, damping_active_out;
   int bad_count = 0;
   int total_checks = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   echo_filter_voice_detect_cfg #(.STEP_CYC(20), .CHANNELS(32)) i_dut (.clk_sys_in, .reset_n_in,
      .reg_req_in, .reg_rdata_out, .delay_range_sel_0_in, .delay_range_sel_1_in,
      .quiet_hysteresis_enable_in, .quiet_amplitude_floor_in, .coeff_freeze_in, .sample_valid_in,
      .sample_in, .effective_delay_out, .chan_processed_out, .quiet_valid_out, .quiet_chan_out,
      .quiet_flag_out, .damping_active_out, .rx_dither_out);
   task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      reg_req_in = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk_sys_in);
      reg_req_in.wr = 1'b0;
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys_in);
      reg_req_in = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clk_sys_in);
      reg_req_in.rd = 1'b0;
      chk(reg_rdata_out, exp, "register read");
   endtask : reg_chk
   task automatic send(input logic [4:0] ch, input logic [3:0] lv, input logic [7:0] am = 8'h00);
      @(negedge clk_sys_in);
      sample_valid_in = 1'b1;
      sample_in = '{chan: ch, amp: am, level: lv};
      @(negedge clk_sys_in);
      sample_valid_in = 1'b0;
   endtask : send
   task automatic test_regs;
      logic [7:0] rst_tab [6];
      rst_tab = '{8'h00, 8'h44, 8'h0F, 8'h77, 8'h74, 8'h85};
      chk(rx_dither_out, 8'h00, "dither after reset");
      chk(damping_active_out, 1'b0, "damping in reset");
      @(negedge clk_sys_in);
      chk(damping_active_out, 1'b1, "damping after reset");
      for (int i = 0; i < 6; i++) reg_chk(8'h70 + 8'(i), rst_tab[i]);
      reg_wr(8'h76, 8'hFF);
      reg_chk(8'h76, 8'h00);
      reg_chk(8'h6F, 8'h00);
      reg_wr(SPRING_TIMER_CFG_ADDR, 8'hFF);
      reg_chk(SPRING_TIMER_CFG_ADDR, 8'h77);
      reg_wr(ECHO_PATH_DELAY_ADDR, 8'hFF);
      reg_chk(ECHO_PATH_DELAY_ADDR, 8'h0F);
      reg_wr(SAWTOOTH_OFFSET_CFG_ADDR, 8'hA5);
      reg_chk(SAWTOOTH_OFFSET_CFG_ADDR, 8'hA5);
      reg_wr(SPRING_TIMER_CFG_ADDR, 8'h44);
      reg_wr(SAWTOOTH_OFFSET_CFG_ADDR, 8'h00);
      $display("test_regs done");
   endtask : test_regs
   task automatic test_delay;
      for (int s = 0; s < 2; s++) begin
         delay_range_sel_1_in = s[0];
         for (int c = 0; c < 16; c++) begin
            reg_wr(ECHO_PATH_DELAY_ADDR, 8'(c));
            @(negedge clk_sys_in);
            chk(effective_delay_out, (s == 1 || c < 8) ? 11'(c) : 11'h007, "delay code");
         end
      end
      $display("test_delay done");
   endtask : test_delay
   task automatic test_split;
      delay_range_sel_1_in = 1'b1;
      for (int m = 0; m < 2; m++) begin
         delay_range_sel_0_in = m[0];
         for (int ch = 0; ch < 32; ch++) begin
            send(5'(ch), 4'h0);
            chk(chan_processed_out, ch[2] == m[0], "processed channel");
            chk(quiet_valid_out, ch[2] == m[0], "channel answered");
         end
      end
      delay_range_sel_0_in = 1'b0;
      delay_range_sel_1_in = 1'b0;
      send(5'h05, 4'h0);
      chk(quiet_valid_out, 1'b1, "short mode channel");
      $display("test_split done");
   endtask : test_split
   task automatic test_damp;
      coeff_freeze_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      chk(damping_active_out, 1'b0, "damping frozen");
      coeff_freeze_in = 1'b0;
      reg_wr(SPRING_TIMER_CFG_ADDR, 8'h00);
      @(negedge clk_sys_in);
      chk(damping_active_out, 1'b0, "damping off");
      reg_wr(SPRING_TIMER_CFG_ADDR, 8'h44);
      @(negedge clk_sys_in);
      chk(damping_active_out, 1'b1, "damping on");
      $display("test_damp done");
   endtask : test_damp
   task automatic test_saw;
      reg_wr(SAWTOOTH_OFFSET_CFG_ADDR, 8'h0F);
      repeat (40) @(negedge clk_sys_in);
      chk(rx_dither_out != 8'h00, 1'b1, "dither present");
      reg_wr(SAWTOOTH_OFFSET_CFG_ADDR, 8'h00);
      repeat (3) @(negedge clk_sys_in);
      chk(rx_dither_out, 8'h00, "dither removed");
      $display("test_saw done");
   endtask : test_saw
   task automatic test_quiet;
      quiet_case_t q [8];
      q = '{{2'b00, 4'h0, 8'hFB, 8'h01, 8'h00, 1'b1},
            {2'b00, 4'h0, 8'hFA, 8'h01, 8'h00, 1'b0},
            {2'b00, 4'h0, 8'hFA, 8'h01, 8'h01, 1'b1},
            {2'b01, 4'h0, 8'hFA, 8'hF0, 8'h00, 1'b1},
            {2'b00, 4'h0, 8'hFF, 8'h00, 8'h00, 1'b0},
            {2'b00, 4'h1, 8'hFF, 8'h01, 8'h00, 1'b0},
            {2'b10, 4'h0, 8'hFE, 8'h01, 8'h00, 1'b1},
            {2'b10, 4'h0, 8'hFD, 8'h01, 8'h00, 1'b0}};
      for (int i = 0; i < 8; i++) begin
         delay_range_sel_1_in = q[i].lg;
         quiet_hysteresis_enable_in = q[i].hy;
         quiet_amplitude_floor_in = q[i].fl;
         reg_wr(VOICE_DETECT_COUNT_INIT_ADDR, q[i].ci);
         reg_wr(VOICE_DETECT_HYST_GAP_ADDR, q[i].hg);
         reg_wr(VOICE_DETECT_INTERVALS_ADDR, q[i].iv);
         repeat (80) send(5'h00, 4'h0);
         chk(quiet_chan_out, 5'h00, "quiet channel");
         chk(quiet_flag_out, q[i].ex, "no-voice flag");
      end
      $display("test_quiet done");
   endtask : test_quiet
   task automatic test_max;
      delay_range_sel_1_in = 1'b0;
      quiet_hysteresis_enable_in = 1'b0;
      quiet_amplitude_floor_in = 4'h0;
      reg_wr(VOICE_DETECT_COUNT_INIT_ADDR, 8'hFB);
      reg_wr(VOICE_DETECT_HYST_GAP_ADDR, 8'h04);
      reg_wr(VOICE_DETECT_INTERVALS_ADDR, 8'h00);
      repeat (80) send(5'h00, 4'h0, 8'h40);
      chk(quiet_flag_out, 1'b1, "steady amplitude");
      // half the values sit 16 below the window maximum, outside the margin
      repeat (40) begin
         send(5'h00, 4'h0, 8'h40);
         send(5'h00, 4'h0, 8'h30);
      end
      chk(quiet_flag_out, 1'b0, "amplitude off maximum");
      $display("test_max done");
   endtask : test_max
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (5) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      test_regs();
      test_delay();
      test_split();
      test_damp();
      test_saw();
      test_quiet();
      test_max();
      stop_test();
   end
   initial begin
      #1000000;
      bad_count++;
      $display("watchdog expired");
      stop_test();
   end
endmodule : echo_filter_voice_detect_cfg_test
`default_nettype wire
